/* rtl/fcq_pkg.sv */
// Notes on behaviour
// - Query command 98h at 55h enters query.
// - Query holds until reset command; then array.
// - Query command also accepted from autoselect mode.
// - Words 10h-12h read 0051h, 0052h, 0059h.
// - Command set identifier: 0002h, 0000h.
// - Extended table pointer: 0040h, 0000h.
// - Words 17h to 1Ah read zero.
// - Supply minimum 0017h, maximum 0019h.
// - Programming supply words 1Dh, 1Eh read zero.
// - Typical timeouts: 0004h, 0000h, 0009h, 0000h.
// - Maximum timeout multipliers: 0004h, 0000h, 0004h, 0000h.
// - Device size word reads 0016h.
// - Interface 0001h, 0000h; multi-byte write zero.
// - Erase region count reads 0003h.
// - Regions 1, 3 descriptors; region 4 zero.
// - Region 2 reads 003Dh, 0000h, 0000h, 0001h.
// - Extended table string and version words.
// - Feature words 45h to 49h, 50h.
// - Sector count, burst, page mode words.
// - Acceleration supply minimum 00B5h, maximum 00C5h.
// - Boot flag 02h bottom, 03h top.
// - Bank count and per-bank sector counts.
package fcq_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus geometry.
    ////////////////////////////////////////////////////////////////////////////

    // Word address width of a 2M x 16 array.
    localparam int FCQ_ADDR_W = 21;
    // Data bus width.
    localparam int FCQ_DATA_W = 16;
    // Width of the command byte and of the decoded address slice.
    localparam int FCQ_CMD_W  = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Commands.
    ////////////////////////////////////////////////////////////////////////////

    // Query command byte and the word address it must be written to.
    localparam logic [7:0] FCQ_CMD_QUERY = 8'h98;
    localparam logic [7:0] FCQ_CMD_ADDR  = 8'h55;
    // Reset command byte; its address is a don't care.
    localparam logic [7:0] FCQ_CMD_RESET = 8'hf0;

    ////////////////////////////////////////////////////////////////////////////
    // Query table.
    ////////////////////////////////////////////////////////////////////////////

    // First and last word address of the table.
    localparam logic [FCQ_ADDR_W-1:0] FCQ_TBL_FIRST = 21'h000010;
    localparam logic [FCQ_ADDR_W-1:0] FCQ_TBL_LAST  = 21'h00005b;
    // Number of entries, 10h through 5Bh.
    localparam int FCQ_TBL_N = 76;
    // Word address of the boot-location flag.
    localparam logic [FCQ_ADDR_W-1:0] FCQ_BOOT_ADDR = 21'h00004f;
    // Boot-location flag values.
    localparam logic [7:0] FCQ_BOOT_BOTTOM = 8'h02;
    localparam logic [7:0] FCQ_BOOT_TOP    = 8'h03;
    // Reset value of the data output.
    localparam logic [FCQ_DATA_W-1:0] FCQ_DOUT_RST = 16'h0000;

    // Low bytes of the table, index 0 being word 10h. The boot flag slot holds
    // zero here and is filled from the variant by the lookup.
    localparam logic [7:0] FCQ_TABLE [0:FCQ_TBL_N-1] = '{
        8'h51, 8'h52, 8'h59,                        // 10h-12h
        8'h02, 8'h00, 8'h40, 8'h00,                 // 13h-16h
        8'h00, 8'h00, 8'h00, 8'h00,                 // 17h-1Ah
        8'h17, 8'h19, 8'h00, 8'h00,                 // 1Bh-1Eh
        8'h04, 8'h00, 8'h09, 8'h00,                 // 1Fh-22h
        8'h04, 8'h00, 8'h04, 8'h00,                 // 23h-26h
        8'h16, 8'h01, 8'h00, 8'h00, 8'h00, 8'h03,   // 27h-2Ch
        8'h03, 8'h00, 8'h40, 8'h00,                 // 2Dh-30h
        8'h3d, 8'h00, 8'h00, 8'h01,                 // 31h-34h
        8'h03, 8'h00, 8'h40, 8'h00,                 // 35h-38h
        8'h00, 8'h00, 8'h00, 8'h00,                 // 39h-3Ch
        8'h00, 8'h00, 8'h00,                        // 3Dh-3Fh
        8'h50, 8'h52, 8'h49, 8'h31, 8'h33,          // 40h-44h
        8'h04, 8'h02, 8'h01, 8'h00, 8'h05,          // 45h-49h
        8'h33, 8'h01, 8'h00,                        // 4Ah-4Ch
        8'hb5, 8'hc5, 8'h00, 8'h00,                 // 4Dh-50h
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,   // 51h-56h
        8'h04, 8'h13, 8'h10, 8'h10, 8'h13           // 57h-5Bh
    };

    // Query mode of the responder.
    typedef enum logic {
        FCQ_MODE_ARRAY,
        FCQ_MODE_QUERY
    } fcq_mode_t;

endpackage

/* rtl/fcq_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for a group of pin levels.
module fcq_sync
    import fcq_pkg::*;
#(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset.
    input  wire logic         clk_in,
    input  wire logic         sys_rst_in,
    // Pin side.
    input  wire logic [W-1:0] pins_in,
    // Clock side.
    output logic      [W-1:0] sync_out
);

    // First stage; read only by the second stage.
    logic [W-1:0] meta_reg;

    // Both stages reset to the idle level of the pins.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            meta_reg <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_reg <= pins_in;
            sync_out <= meta_reg;
        end
    end

endmodule // fcq_sync

/* rtl/fcq_table.sv */
`timescale 1ns/1ps
// Combinational lookup of the query table.
module fcq_table
    import fcq_pkg::*;
#(
    parameter logic BOOT_TOP = 1'b0
) (
    // Word address.
    input  wire logic [FCQ_ADDR_W-1:0] addr_in,
    // Table word.
    output logic      [FCQ_DATA_W-1:0] data_out
);

    // Offset into the table, valid only inside the listed range.
    logic [FCQ_ADDR_W-1:0] offset;

    // Listed words carry the value on the low byte, the high byte is zero.
    always_comb begin
        offset = addr_in - FCQ_TBL_FIRST;
        if (addr_in == FCQ_BOOT_ADDR) begin
            // The boot flag depends on the built variant.
            data_out = {8'h00, (BOOT_TOP ? FCQ_BOOT_TOP : FCQ_BOOT_BOTTOM)};
        end else if (addr_in >= FCQ_TBL_FIRST && addr_in <= FCQ_TBL_LAST) begin
            data_out = {8'h00, FCQ_TABLE[offset[6:0]]};
        end else begin
            // Anything outside the table reads as zero.
            data_out = '0;
        end
    end

endmodule // fcq_table

/* rtl/fcq_top.sv */
`timescale 1ns/1ps
// Query-mode responder of a 16-bit parallel flash.
//
// The host drives ordinary asynchronous write and read cycles on the pins. All
// pins are sampled on clk_in, so a cycle must stay valid for several clock
// periods; at 250 MHz the documented access times leave ample room.
module fcq_top
    import fcq_pkg::*;
#(
    // Boot-location variant: 0 bottom boot, 1 top boot.
    parameter logic BOOT_TOP = 1'b0
) (
    // Clock and reset.
    input  wire logic                  clk_in,
    input  wire logic                  sys_rst_in,
    // Flash bus pins from the host.
    input  wire logic                  chip_en_n_in,
    input  wire logic                  write_en_n_in,
    input  wire logic                  out_en_n_in,
    input  wire logic [FCQ_ADDR_W-1:0] addr_in,
    input  wire logic [FCQ_DATA_W-1:0] dq_in,
    // Data pins toward the host.
    output logic      [FCQ_DATA_W-1:0] dq_out,
    output logic                       dq_oe_out,
    // Device state from the surrounding command logic.
    input  wire logic                  array_ready_in,
    input  wire logic                  autoselect_mode_in,
    // Mode flag.
    output logic                       query_mode_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.
    ////////////////////////////////////////////////////////////////////////////

    // Width of the synchronised pin group: three strobes, address and data.
    localparam int PIN_W = 3 + FCQ_ADDR_W + FCQ_DATA_W;
    // Strobes idle high, address and data idle low.
    localparam logic [PIN_W-1:0] PIN_IDLE = {3'b111, {(FCQ_ADDR_W + FCQ_DATA_W){1'b0}}};

    // Synchronised pin group.
    logic [PIN_W-1:0] pins_sync;
    // Synchronised chip enable, active low.
    logic ce_n_s;
    // Synchronised write enable, active low.
    logic we_n_s;
    // Synchronised output enable, active low.
    logic oe_n_s;
    // Synchronised address.
    logic [FCQ_ADDR_W-1:0] addr_s;
    // Synchronised data input.
    logic [FCQ_DATA_W-1:0] dq_s;

    // Every pin passes two flip-flops before the logic looks at it.
    fcq_sync #(
        .W       (PIN_W),
        .RST_VAL (PIN_IDLE)
    ) u_sync (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .pins_in    ({chip_en_n_in, write_en_n_in, out_en_n_in, addr_in, dq_in}),
        .sync_out   (pins_sync)
    );

    // Split the group back into its fields.
    assign {ce_n_s, we_n_s, oe_n_s, addr_s, dq_s} = pins_sync;

    ////////////////////////////////////////////////////////////////////////////
    // Table lookup.
    ////////////////////////////////////////////////////////////////////////////

    // Table word for the current synchronised address.
    logic [FCQ_DATA_W-1:0] table_word;

    // The lookup is pure logic; the output flop below registers it.
    fcq_table #(
        .BOOT_TOP (BOOT_TOP)
    ) u_table (
        .addr_in  (addr_s),
        .data_out (table_word)
    );

    ////////////////////////////////////////////////////////////////////////////
    // State.
    ////////////////////////////////////////////////////////////////////////////

    // All state of the responder in one record.
    typedef struct packed {
        fcq_mode_t              mode;     // Array or query mode.
        logic                   we_prev;  // Write enable level one cycle back.
        logic [FCQ_CMD_W-1:0]   wr_addr;  // Low address byte held during a write.
        logic [FCQ_CMD_W-1:0]   wr_data;  // Command byte held during a write.
        logic [FCQ_DATA_W-1:0]  dout;     // Data driven toward the host.
        logic                   doe;      // Data output enable.
        logic                   wr_armed; // A capture was made in this write pulse.
    } fcq_state_t;

    // Registered state.
    fcq_state_t st_reg;
    // Next state.
    fcq_state_t st_next;

    // A write cycle completes on the rising write enable while chip enable is low.
    logic wr_done;
    // A read cycle is active while chip and output enables are both low and write enable is high.
    logic rd_active;
    // The completed write carried the query command at its address.
    logic is_query_cmd;
    // The completed write carried the reset command.
    logic is_reset_cmd;
    // The device is in a mode from which the query command is accepted.
    logic can_enter;

    // Decode of the bus cycle and of the command byte.
    always_comb begin
        wr_done      = we_n_s && !st_reg.we_prev && !ce_n_s && st_reg.wr_armed;
        rd_active    = !ce_n_s && !oe_n_s && we_n_s;
        is_query_cmd = wr_done && (st_reg.wr_data == FCQ_CMD_QUERY)
                       && (st_reg.wr_addr == FCQ_CMD_ADDR);
        is_reset_cmd = wr_done && (st_reg.wr_data == FCQ_CMD_RESET);
        can_enter    = array_ready_in || autoselect_mode_in;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic.
    ////////////////////////////////////////////////////////////////////////////

    // Writes are captured while they stand and acted on when the strobe rises,
    // which is where a parallel flash latches its command data.
    always_comb begin
        st_next         = st_reg;
        st_next.we_prev = we_n_s;

        // A strobe rise counts only after a capture in the same pulse, so a
        // stale command byte is never applied a second time.
        if (we_n_s) begin
            st_next.wr_armed = 1'b0;
        end

        // Hold address and data while the write strobe is low; the last value
        // before the rising edge is the one that counts.
        if (!we_n_s && !ce_n_s) begin
            st_next.wr_addr = addr_s[FCQ_CMD_W-1:0];
            st_next.wr_data = dq_s[FCQ_CMD_W-1:0];
            st_next.wr_armed = 1'b1;
        end

        // Mode transitions.
        case (st_reg.mode)
            FCQ_MODE_ARRAY: begin
                // Entry from array reads or from autoselect mode.
                if (is_query_cmd && can_enter) begin
                    st_next.mode = FCQ_MODE_QUERY;
                end
            end
            FCQ_MODE_QUERY: begin
                // Only the reset command leaves; other writes are ignored.
                if (is_reset_cmd) begin
                    st_next.mode = FCQ_MODE_ARRAY;
                end
            end
            default: begin
                st_next.mode = FCQ_MODE_ARRAY;
            end
        endcase

        // Reads in query mode return the table word. Outside query mode the
        // array path owns the data pins, so this block stays off them.
        if (st_reg.mode == FCQ_MODE_QUERY && rd_active) begin
            st_next.dout = table_word;
            st_next.doe  = 1'b1;
        end else begin
            st_next.dout = FCQ_DOUT_RST;
            st_next.doe  = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register.
    ////////////////////////////////////////////////////////////////////////////

    // A hardware reset returns the device to array reads.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_reg.mode    <= FCQ_MODE_ARRAY;
            st_reg.we_prev <= 1'b1;
            st_reg.wr_addr <= 8'h00;
            st_reg.wr_data <= 8'h00;
            st_reg.dout    <= FCQ_DOUT_RST;
            st_reg.doe     <= 1'b0;
            st_reg.wr_armed <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.
    ////////////////////////////////////////////////////////////////////////////

    // Every output is a flop of the state record.
    assign dq_out         = st_reg.dout;
    assign dq_oe_out      = st_reg.doe;
    assign query_mode_out = (st_reg.mode == FCQ_MODE_QUERY);

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.
    ////////////////////////////////////////////////////////////////////////////

    // A query read at the given address in the current cycle.
    sequence s_qread(logic [FCQ_ADDR_W-1:0] a);
        (st_reg.mode == FCQ_MODE_QUERY) && rd_active && (addr_s == a);
    endsequence

    // The query command taken from array reads.
    sequence s_enter_array;
        is_query_cmd && array_ready_in && (st_reg.mode == FCQ_MODE_ARRAY);
    endsequence

    // The query command taken from autoselect mode.
    sequence s_enter_auto;
        is_query_cmd && autoselect_mode_in && (st_reg.mode == FCQ_MODE_ARRAY);
    endsequence

    // Entry from array reads sets the mode flag at the next edge.
    a_query_enter: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_enter_array |=> query_mode_out)
        else $error("query command did not enter query mode");

    // Entry from autoselect mode, and the flag is still set one cycle on when no reset command follows.
    a_auto_enter: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_enter_auto ##1 !is_reset_cmd |=> query_mode_out)
        else $error("query command from autoselect not honoured");

    // Query mode holds on any write other than the reset command.
    a_query_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        query_mode_out && !is_reset_cmd |=> query_mode_out)
        else $error("query mode left without reset command");

    // The reset command returns to array reads and drops the data pins.
    a_reset_exit: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        query_mode_out && is_reset_cmd |=> !query_mode_out ##1 !dq_oe_out)
        else $error("reset command did not leave query mode");

    // A wrong address or byte never enters query mode.
    a_entry_guard: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !query_mode_out && !is_query_cmd |=> !query_mode_out)
        else $error("query mode entered without the query command");

    // The first word of the identification string appears on the pins.
    a_id_string: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_qread(21'h000010) |=> dq_oe_out && dq_out == 16'h0051)
        else $error("word 10h did not read 0051h");

    // Region 2 descriptor head word.
    a_region2_word: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_qread(21'h000031) |=> dq_out == 16'h003d)
        else $error("word 31h did not read 003Dh");

    // Boot flag follows the variant.
    a_boot_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_qread(FCQ_BOOT_ADDR) |=> dq_out == (BOOT_TOP ? 16'h0003 : 16'h0002))
        else $error("boot flag word wrong");

    // Acceleration supply minimum.
    a_acc_minimum: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_qread(21'h00004d) |=> dq_out == 16'h00b5)
        else $error("word 4Dh did not read 00B5h");

    // Reads beyond the table return zero while still driving the pins.
    a_unlisted_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (st_reg.mode == FCQ_MODE_QUERY) && rd_active && (addr_s > FCQ_TBL_LAST)
        |=> dq_oe_out && dq_out == 16'h0000)
        else $error("unlisted word did not read zero");

    // The high byte is zero whenever the block drives.
    a_high_byte_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        dq_oe_out |-> dq_out[15:8] == 8'h00)
        else $error("high byte not zero");

    // Outside query mode the data pins are never driven.
    a_array_quiet: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !query_mode_out |=> !dq_oe_out)
        else $error("data driven outside query mode");

    // A listed word read in query mode is driven at the next edge.
    property p_word(logic [FCQ_ADDR_W-1:0] a, logic [FCQ_DATA_W-1:0] w);
        @(posedge clk_in) disable iff (sys_rst_in)
        s_qread(a) |=> dq_oe_out && dq_out == w;
    endproperty

    // Command set identifier.
    a_cmd_set: assert property (p_word(21'h13, 16'h0002))
        else $error("word 13h wrong");

    // Extended table pointer.
    a_ext_pointer: assert property (p_word(21'h15, 16'h0040))
        else $error("word 15h wrong");

    // Supply minimum.
    a_supply_min: assert property (p_word(21'h1b, 16'h0017))
        else $error("word 1Bh wrong");

    // Typical block erase timeout.
    a_erase_typical: assert property (p_word(21'h21, 16'h0009))
        else $error("word 21h wrong");

    // Maximum word write multiplier.
    a_write_max: assert property (p_word(21'h23, 16'h0004))
        else $error("word 23h wrong");

    // Device size.
    a_device_size: assert property (p_word(21'h27, 16'h0016))
        else $error("word 27h wrong");

    // Interface description.
    a_iface_code: assert property (p_word(21'h28, 16'h0001))
        else $error("word 28h wrong");

    // Erase region count.
    a_region_count: assert property (p_word(21'h2c, 16'h0003))
        else $error("word 2Ch wrong");

    // Region 1 head word.
    a_region1_word: assert property (p_word(21'h2d, 16'h0003))
        else $error("word 2Dh wrong");

    // Extended table string head.
    a_ext_string: assert property (p_word(21'h40, 16'h0050))
        else $error("word 40h wrong");

    // Suspend feature word.
    a_suspend_word: assert property (p_word(21'h46, 16'h0002))
        else $error("word 46h wrong");

    // Simultaneous operation sector count.
    a_sector_count: assert property (p_word(21'h4a, 16'h0033))
        else $error("word 4Ah wrong");

    // Bank count.
    a_bank_count: assert property (p_word(21'h57, 16'h0004))
        else $error("word 57h wrong");

endmodule // fcq_top

/* verif/fcq_host_model.sv */
`timescale 1ns/1ps
// Behavioural host that runs asynchronous write and read cycles on the flash pins.
module fcq_host_model
    import fcq_pkg::*;
(
    // Clock used only to pace the pin changes.
    input  wire logic                  clk_in,
    // Pins toward the responder.
    output logic                       chip_en_n_out,
    output logic                       write_en_n_out,
    output logic                       out_en_n_out,
    output logic      [FCQ_ADDR_W-1:0] addr_out,
    output logic      [FCQ_DATA_W-1:0] dq_out
);
    // Idle bus: all strobes high, data lines away from any command value.
    initial begin
        chip_en_n_out  = 1'b1;
        write_en_n_out = 1'b1;
        out_en_n_out   = 1'b1;
        addr_out       = '0;
        dq_out         = 16'h5aa5;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Moves just after a clock edge, as every bus master here does.
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // One command write; each strobe level lasts three periods so the
    // two-stage synchroniser cannot miss it.
    task automatic write_word(input logic [FCQ_ADDR_W-1:0] a, input logic [FCQ_DATA_W-1:0] d);
        step(1);
        chip_en_n_out  = 1'b0;
        write_en_n_out = 1'b0;
        out_en_n_out   = 1'b1;
        addr_out       = a;
        dq_out         = d;
        step(3);
        write_en_n_out = 1'b1;
        // Chip enable stays low until the rise of we_n has surely been seen.
        step(3);
        chip_en_n_out  = 1'b1;
        // Released lines must not keep showing the written value.
        dq_out         = ~d;
        addr_out       = ~a;
    endtask

    // Starts or moves a read; the pins stay put until read_release.
    task automatic read_addr(input logic [FCQ_ADDR_W-1:0] a);
        step(1);
        chip_en_n_out = 1'b0;
        out_en_n_out  = 1'b0;
        addr_out      = a;
    endtask

    // Ends a read and scrambles the address lines.
    task automatic read_release();
        step(1);
        chip_en_n_out = 1'b1;
        out_en_n_out  = 1'b1;
        addr_out      = ~addr_out;
    endtask
endmodule // fcq_host_model

/* verif/flash_cfi_query_responder_test.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        bad_count++; \
        $display("[FAIL] %0t got %h expected %h", $time, (got), (exp)); \
    end \
end
module flash_cfi_query_responder_test;
    import fcq_pkg::*;

    logic                  clk = 1'b0;     // 250 MHz clock.
    logic                  rst = 1'b1;     // Asynchronous reset.
    logic                  ready = 1'b0;   // Device ready to read array data.
    logic                  autosel = 1'b0; // Device in autoselect mode.
    logic                  ce_n, we_n, oe_n;
    logic [FCQ_ADDR_W-1:0] addr;
    logic [FCQ_DATA_W-1:0] dq_h, dq0, dq1;
    logic                  oe0, oe1, q0, q1;
    int                    bad_count = 0;
    int                    comparisons = 0;
    bit                    model_query = 1'b0; // Bench view of the mode.
    logic [7:0]            exp_tbl [int];      // Nonzero table words by address.
    // Nonzero entries as address and low byte; 4Fh depends on the variant.
    int unsigned nz[$] = '{'h1051, 'h1152, 'h1259, 'h1302, 'h1540, 'h1b17, 'h1c19,
        'h1f04, 'h2109, 'h2304, 'h2504, 'h2716, 'h2801, 'h2c03, 'h2d03, 'h2f40,
        'h313d, 'h3401, 'h3503, 'h3740, 'h4050, 'h4152, 'h4249, 'h4331, 'h4433,
        'h4504, 'h4602, 'h4701, 'h4905, 'h4a33, 'h4b01, 'h4db5, 'h4ec5, 'h5704,
        'h5813, 'h5910, 'h5a10, 'h5b13};

    always #2 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    // Host model and the two boot variants, fed from the same pins.
    fcq_host_model fcq_host_model_i (.clk_in(clk), .chip_en_n_out(ce_n),
        .write_en_n_out(we_n), .out_en_n_out(oe_n), .addr_out(addr), .dq_out(dq_h));

    fcq_top #(.BOOT_TOP(1'b0)) fcq_top_i (.clk_in(clk), .sys_rst_in(rst),
        .chip_en_n_in(ce_n), .write_en_n_in(we_n), .out_en_n_in(oe_n), .addr_in(addr),
        .dq_in(dq_h), .dq_out(dq0), .dq_oe_out(oe0), .array_ready_in(ready),
        .autoselect_mode_in(autosel), .query_mode_out(q0));

    // Second copy exists only to see the top-boot flag word.
    fcq_top #(.BOOT_TOP(1'b1)) fcq_top_i2 (.clk_in(clk), .sys_rst_in(rst),
        .chip_en_n_in(ce_n), .write_en_n_in(we_n), .out_en_n_in(oe_n), .addr_in(addr),
        .dq_in(dq_h), .dq_out(dq1), .dq_oe_out(oe1), .array_ready_in(ready),
        .autoselect_mode_in(autosel), .query_mode_out(q1));

    ////////////////////////////////////////////////////////////////////////////
    // Expected word; silent bus outside query mode, zero for unlisted places.
    function automatic logic [15:0] model_word(input int a, input bit top);
        if (!model_query) return 16'h0000;
        if (a == 'h4f) return top ? 16'h0003 : 16'h0002;
        if (exp_tbl.exists(a)) return {8'h00, exp_tbl[a]};
        return 16'h0000;
    endfunction

    // Command write, mirrored in the bench model, then the mode is compared.
    task automatic cmd(input logic [20:0] a, input logic [15:0] d);
        fcq_host_model_i.write_word(a, d);
        if (!model_query && d[7:0] == 8'h98 && a[7:0] == 8'h55 && (ready || autosel))
            model_query = 1'b1;
        else if (model_query && d[7:0] == 8'hf0)
            model_query = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        `CHK(q0, logic'(model_query))
        `CHK(q1, logic'(model_query))
    endtask

    // Read whose result has had four edges to settle through the synchroniser.
    task automatic rd(input logic [20:0] a);
        fcq_host_model_i.read_addr(a);
        repeat (4) @(posedge clk);
        #1;
        `CHK(oe0, logic'(model_query))
        `CHK(oe1, logic'(model_query))
        `CHK(dq0, model_word(int'(a), 1'b0))
        `CHK(dq1, model_word(int'(a), 1'b1))
    endtask

    // Ends a read and checks that the bottom-boot copy lets go of the bus.
    task automatic rd_end();
        fcq_host_model_i.read_release();
        repeat (4) @(posedge clk);
        #1;
        `CHK(oe0, 1'b0)
        `CHK(dq0, 16'h0000)
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watchdog: the sequence needs well under 3000 cycles.
    initial begin
        #(4 * 20000);
        bad_count++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] b;
        foreach (nz[k]) exp_tbl[int'(nz[k] >> 8)] = nz[k][7:0];
        void'($urandom(24));
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        // Outside query mode the table stays hidden.
        rd(21'h10);
        rd_end();
        // Query command with no ready state, wrong address, wrong data.
        cmd(21'h55, 16'h0098);
        ready = 1'b1;
        cmd(21'h56, 16'h0098);
        cmd(21'h55, 16'h0099);
        // Entry, with random upper address bits that must be ignored.
        cmd({13'($urandom), 8'h55}, 16'h0098);
        // Back-to-back sweep of the table and its surroundings.
        for (int a = 0; a < 'h60; a++) rd(21'(a));
        for (int i = 0; i < 8; i++) rd({13'($urandom) | 13'h1, 8'($urandom)});
        rd_end();
        // Other writes in query mode, a second query among them, change nothing.
        for (int i = 0; i < 5; i++) begin
            b = (i == 0) ? 8'h98 : 8'($urandom);
            if (b == 8'hf0) b = 8'h90;
            cmd(21'($urandom), {8'h00, b});
        end
        rd(21'h4f);
        rd_end();
        // Reset command at any address returns to array reads.
        cmd(21'($urandom), 16'h00f0);
        rd(21'h11);
        rd_end();
        // Entry from autoselect mode alone, then left by reset command.
        ready = 1'b0;
        autosel = 1'b1;
        cmd(21'h155, 16'h0098);
        rd(21'h12);
        rd_end();
        cmd(21'h0, 16'h00f0);
        // Query again, then a hardware reset in mid-run clears the mode.
        cmd(21'h55, 16'h0098);
        rst = 1'b1;
        model_query = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        `CHK(q0, 1'b0)
        rd(21'h10);
        rd_end();
        give_verdict();
    end
endmodule // flash_cfi_query_responder_test
